// *** logic/hcr_sync_check.sv ***
/*
 * receiver for rolling-code words: pwm bit capture, field split,
 * transmitter lookup, counter window check, resync and learning,
 * apb registers and interrupt.
 * assumes: rf_data is demodulated and synchronous to pclk; an outside
 * unit decrypts the hopping code and derives learn keys.
 */
// Added by the designer: the register offsets and the APB slave port.
// Function
// (R1) word opens with 32-bit encrypted hopping part
// (R2) 28-bit plain transmitter identifier follows
// (R3) 4-bit button field follows identifier
// (R4) extended mode: button plus identifier, 32 bits
// (R5) one battery state bit follows
// (R6) one to five status bits follow
// (R7) keep first 66 bits, drop rest
// (R8) only pwm, time unit 200-400 us
// (R9) transmitter counter at least 16 bits
// (R10) accept only counter above stored value
// (R11) 1..16 ahead: accept, store, drive output
// (R12) 17..32k ahead: hold, await second word
// (R13) consecutive second word: resync and drive
// (R14) 32k..64k ahead: ignore, no change
// (R15) learning stores identifier, key, counter
// (R16) transmitter starts on any button high
// (R17) button field selects one of 15 outputs
// (R18) non-consecutive second word replaces held value
`timescale 1ns/1ns
`include "hcr_params.svh"
module hcr_sync_check #(
	parameter int N_TX       = 4,
	parameter int KEY_W      = 64,
	parameter int UNIT_MIN_CYC = `HCR_UNIT_MIN_CYC,
	parameter int UNIT_MAX_CYC = `HCR_UNIT_MAX_CYC
) (
	// apb slave
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// radio data
	input  wire logic             rf_data,
	// decrypt unit
	output logic                  dec_req,
	output logic      [31:0]      dec_hop,
	output logic      [31:0]      dec_serial,
	output logic      [KEY_W-1:0] dec_key_in,
	output logic                  dec_learn,
	input  wire logic             dec_done,
	input  wire logic [15:0]      dec_counter,
	input  wire logic [KEY_W-1:0] dec_key,
	// functions and interrupt
	output logic      [14:0]      func_out,
	output logic                  low_battery,
	output logic                  irq
);

	localparam int AW = (N_TX > 1) ? $clog2(N_TX) : 1;
	localparam int CW = `HCR_CNT_W;
	localparam int EW = KEY_W + 32 + CW;
	localparam logic [15:0] PER_MIN = 16'(3 * UNIT_MIN_CYC);
	localparam logic [15:0] PER_MAX = 16'(3 * UNIT_MAX_CYC);
	localparam logic [15:0] HI_MIN  = 16'(UNIT_MIN_CYC);
	localparam logic [15:0] HI_MAX  = 16'(2 * UNIT_MAX_CYC);
	localparam logic [6:0]  NBITS   = 7'(`HCR_WORD_BITS);

	logic [2:0]             ctrl;
	logic [`HCR_ST_W-1:0]   status;
	logic [`HCR_ST_W-1:0]   mask;
	logic [`HCR_ST_W-1:0]   st_set;
	logic                   rf_prev;
	logic                   seen_high;
	logic [15:0]            h_cnt;
	logic [15:0]            l_cnt;
	logic [15:0]            p_last;
	logic [6:0]             bit_cnt;
	logic [65:0]            shreg;
	logic                   rx_done;
	logic [3:0]             btn;
	logic                   stat_bit;
	hcr_pkg::hcr_state_t    state;
	logic [AW-1:0]          idx;
	logic [AW-1:0]          learn_ptr;
	logic [N_TX-1:0]        vld;
	logic [CW-1:0]          stored_cnt;
	logic [CW-1:0]          rx_cnt;
	logic [CW-1:0]          last_cnt;
	logic                   hold_vld;
	logic [AW-1:0]          hold_idx;
	logic [CW-1:0]          hold_cnt;
	logic [EW-1:0]          rd_data;
	logic                   mem_we;
	logic [AW-1:0]          mem_waddr;
	logic [EW-1:0]          mem_wdata;

	// bus decode
	wire        wr_acc  = psel && penable && pwrite;
	wire        rd_setup = psel && !penable && !pwrite;
	wire        mapped  = (paddr == `HCR_OFS_CTRL) || (paddr == `HCR_OFS_STATUS) ||
	                      (paddr == `HCR_OFS_MASK) || (paddr == `HCR_OFS_HOP) ||
	                      (paddr == `HCR_OFS_SERIAL) || (paddr == `HCR_OFS_INFO) ||
	                      (paddr == `HCR_OFS_COUNT) || (paddr == `HCR_OFS_FUNC);

	// pwm measurement
	wire        rise    = rf_data && !rf_prev;
	wire [16:0] per_sum = {1'b0, h_cnt} + {1'b0, l_cnt};
	wire [15:0] period  = per_sum[16] ? 16'hffff : per_sum[15:0];
	wire        per_ok  = (period >= PER_MIN) && (period <= PER_MAX);
	wire        gap     = !rf_data && seen_high && (l_cnt == PER_MAX);
	wire        last_ok = (h_cnt >= HI_MIN) && (h_cnt <= HI_MAX);
	wire        last_bit = ({h_cnt, 1'b0} < {1'b0, p_last});

	// window judgement
	wire [CW-1:0] diff     = rx_cnt - stored_cnt;
	wire [CW-1:0] hold_nxt = hold_cnt + CW'(1);
	wire          judging  = (state == hcr_pkg::ST_JUDGE) && !ctrl[`HCR_CTRL_LEARN];
	wire          learning = (state == hcr_pkg::ST_JUDGE) && ctrl[`HCR_CTRL_LEARN];
	wire          too_old  = (diff == '0) || diff[CW-1]; // see (R10) see (R14)
	wire          in_open  = !too_old && (diff <= `HCR_WIN_OPEN);
	wire          consec   = hold_vld && (hold_idx == idx) && (rx_cnt == hold_nxt);
	wire          acc      = judging && (in_open || (!too_old && consec));
	wire          do_hold  = judging && !too_old && !in_open && !consec;
	wire          match    = vld[idx] && (rd_data[CW +: 32] == dec_serial);
	wire          last_idx = (idx == AW'(N_TX - 1));
	wire          word_in  = (state == hcr_pkg::ST_IDLE) && rx_done && ctrl[`HCR_CTRL_EN];

	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign irq     = |(status & mask);
	assign dec_learn = ctrl[`HCR_CTRL_LEARN];

	// control and mask registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= `HCR_CTRL_RST;
			mask <= '0;
		end
		else
		begin
			if (wr_acc && paddr == `HCR_OFS_CTRL)
				ctrl <= pwdata[2:0];
			if (wr_acc && paddr == `HCR_OFS_MASK)
				mask <= pwdata[`HCR_ST_W-1:0];
			if (learning)
				ctrl[`HCR_CTRL_LEARN] <= 1'b0;
		end
	end

	// sticky status, a new event outlasts a same-cycle clear
	always_comb
	begin
		st_set = '0;
		st_set[`HCR_ST_WORD] = word_in;
		st_set[`HCR_ST_ACC]  = acc;
		st_set[`HCR_ST_HOLD] = do_hold;
		st_set[`HCR_ST_REJ]  = (judging && too_old) ||
		                       (state == hcr_pkg::ST_CMP && !match && last_idx);
		st_set[`HCR_ST_LRN]  = learning;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status <= '0;
		else if (wr_acc && paddr == `HCR_OFS_STATUS)
			status <= (status & ~pwdata[`HCR_ST_W-1:0]) | st_set;
		else
			status <= status | st_set;
	end

	// read data, loaded in the setup phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (rd_setup)
		begin
			case (paddr)
				`HCR_OFS_CTRL:   prdata <= {29'h0, ctrl};
				`HCR_OFS_STATUS: prdata <= {27'h0, status};
				`HCR_OFS_MASK:   prdata <= {27'h0, mask};
				`HCR_OFS_HOP:    prdata <= dec_hop;
				`HCR_OFS_SERIAL: prdata <= dec_serial;
				`HCR_OFS_INFO:   prdata <= {26'h0, stat_bit, low_battery, btn};
				`HCR_OFS_COUNT:  prdata <= {16'h0, last_cnt};
				`HCR_OFS_FUNC:   prdata <= {17'h0, func_out};
				default:         prdata <= '0;
			endcase
		end
	end

	// pwm bit capture; a bad period restarts the word
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rf_prev   <= 1'b0;
			seen_high <= 1'b0;
			h_cnt     <= '0;
			l_cnt     <= '0;
			p_last    <= '0;
			bit_cnt   <= '0;
			shreg     <= '0;
			rx_done   <= 1'b0;
		end
		else
		begin
			rf_prev <= rf_data;
			rx_done <= 1'b0;
			if (rise)
			begin
				h_cnt     <= '0;
				l_cnt     <= '0;
				seen_high <= 1'b1;
				if (seen_high && per_ok) // see (R8)
				begin
					p_last <= period;
					if (bit_cnt < NBITS) // see (R7)
					begin
						shreg   <= {(h_cnt < l_cnt), shreg[65:1]};
						bit_cnt <= bit_cnt + 7'h01;
					end
				end
				else if (seen_high)
					bit_cnt <= '0; // see (R8)
			end
			else if (gap)
			begin
				// final bit ends in the guard time
				seen_high <= 1'b0;
				bit_cnt   <= '0;
				h_cnt     <= '0;
				if (last_ok && bit_cnt == NBITS - 7'h01)
				begin
					shreg   <= {last_bit, shreg[65:1]};
					rx_done <= 1'b1;
				end
				else if (bit_cnt == NBITS)
					rx_done <= 1'b1; // see (R7)
			end
			else if (rf_data)
				h_cnt <= (h_cnt == 16'hffff) ? h_cnt : h_cnt + 16'h0001;
			else if (l_cnt != 16'hffff)
				l_cnt <= l_cnt + 16'h0001;
		end
	end

	// word fields and sequencing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state       <= hcr_pkg::ST_IDLE;
			idx         <= '0;
			dec_req     <= 1'b0;
			dec_hop     <= '0;
			dec_serial  <= '0;
			dec_key_in  <= '0;
			btn         <= '0;
			low_battery <= 1'b0;
			stat_bit    <= 1'b0;
			stored_cnt  <= '0;
			rx_cnt      <= '0;
		end
		else
		begin
			dec_req <= 1'b0;
			case (state)
				hcr_pkg::ST_IDLE:
					if (word_in)
					begin
						dec_hop     <= shreg[`HCR_HOP_LSB +: 32]; // see (R1)
						btn         <= shreg[`HCR_BTN_LSB +: 4]; // see (R3)
						low_battery <= shreg[`HCR_LOWBAT_BIT]; // see (R5)
						stat_bit    <= shreg[`HCR_STAT_BIT]; // see (R6)
						dec_serial  <= {ctrl[`HCR_CTRL_EXT] ? shreg[`HCR_BTN_LSB +: 4] : 4'h0,
						                shreg[`HCR_SER_LSB +: 28]}; // see (R2) see (R4)
						idx         <= '0;
						dec_key_in  <= '0;
						dec_req     <= ctrl[`HCR_CTRL_LEARN];
						state       <= ctrl[`HCR_CTRL_LEARN] ? hcr_pkg::ST_DEC
						                                     : hcr_pkg::ST_LOOK;
					end
				hcr_pkg::ST_LOOK:
					state <= hcr_pkg::ST_CMP;
				hcr_pkg::ST_CMP:
					if (match)
					begin
						stored_cnt <= rd_data[CW-1:0];
						dec_key_in <= rd_data[EW-1 -: KEY_W];
						dec_req    <= 1'b1;
						state      <= hcr_pkg::ST_DEC;
					end
					else if (last_idx)
						state <= hcr_pkg::ST_IDLE;
					else
					begin
						idx   <= idx + AW'(1);
						state <= hcr_pkg::ST_LOOK;
					end
				hcr_pkg::ST_DEC:
					if (dec_done)
					begin
						rx_cnt <= dec_counter;
						state  <= hcr_pkg::ST_JUDGE;
					end
				hcr_pkg::ST_JUDGE:
					state <= hcr_pkg::ST_IDLE;
				default:
					state <= hcr_pkg::ST_IDLE;
			endcase
		end
	end

	// counter windows and resync hold
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hold_vld <= 1'b0;
			hold_idx <= '0;
			hold_cnt <= '0;
			last_cnt <= '0;
		end
		else if (acc) // see (R10) see (R11) see (R13)
		begin
			hold_vld <= 1'b0;
			last_cnt <= rx_cnt;
		end
		else if (do_hold) // see (R12) see (R18)
		begin
			hold_vld <= 1'b1;
			hold_idx <= idx;
			hold_cnt <= rx_cnt;
		end
	end

	// table of learned transmitters
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			vld       <= '0;
			learn_ptr <= '0;
		end
		else if (learning)
		begin
			vld[learn_ptr] <= 1'b1;
			learn_ptr      <= (learn_ptr == AW'(N_TX - 1)) ? '0 : learn_ptr + AW'(1);
		end
	end

	always_comb
	begin
		mem_we    = learning || acc;
		mem_waddr = learning ? learn_ptr : idx;
		mem_wdata = learning ? {dec_key, dec_serial, rx_cnt} // see (R15)
		                     : {dec_key_in, dec_serial, rx_cnt};
	end

	hcr_store_mem #(
		.W     (EW),
		.DEPTH (N_TX),
		.AW    (AW)
	) u_store (
		.clk   (pclk),
		.rst_n (presetn),
		.we    (mem_we),
		.waddr (mem_waddr),
		.wdata (mem_wdata),
		.raddr (idx),
		.rdata (rd_data)
	);

	// one output pulse per accepted word with a nonzero button field
	genvar gi;
	generate
		for (gi = 0; gi < 15; gi++)
		begin : g_func
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					func_out[gi] <= 1'b0;
				else
					func_out[gi] <= acc && (btn == 4'(gi + 1)); // see (R17)
			end
		end
	endgenerate

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_cap_limit;
		bit_cnt <= NBITS;
	endproperty
	a_cap_limit: assert property (p_cap_limit) else $error("bit count past 66"); // see (R7)

	property p_bad_period;
		(rise && seen_high && !per_ok) |=> (bit_cnt == 7'h00);
	endproperty
	a_bad_period: assert property (p_bad_period) else $error("bad period kept"); // see (R8)

	property p_ext_id;
		word_in |=> (dec_serial[31:28] ==
		             ($past(ctrl[`HCR_CTRL_EXT]) ? $past(shreg[63:60]) : 4'h0));
	endproperty
	a_ext_id: assert property (p_ext_id) else $error("extended id wrong"); // see (R4)

	property p_stale;
		(judging && diff == '0) |=> (func_out == '0) && $stable(last_cnt);
	endproperty
	a_stale: assert property (p_stale) else $error("equal counter taken"); // see (R10)

	property p_open_win;
		(judging && diff != '0 && diff <= `HCR_WIN_OPEN && btn != 4'h0)
			|=> (last_cnt == $past(rx_cnt)) && (func_out != '0);
	endproperty
	a_open_win: assert property (p_open_win) else $error("open window miss"); // see (R11)

	property p_hold;
		(judging && !hold_vld && !too_old && diff > `HCR_WIN_OPEN)
			|=> hold_vld && (hold_cnt == $past(rx_cnt)) && (func_out == '0);
	endproperty
	a_hold: assert property (p_hold) else $error("no hold"); // see (R12)

	property p_resync;
		(judging && !too_old && diff > `HCR_WIN_OPEN && consec)
			|=> !hold_vld && (last_cnt == $past(rx_cnt));
	endproperty
	a_resync: assert property (p_resync) else $error("resync missed"); // see (R13)

	property p_far;
		(judging && diff[CW-1])
			|=> (func_out == '0) && $stable(hold_vld) && $stable(hold_cnt) && $stable(last_cnt);
	endproperty
	a_far: assert property (p_far) else $error("far counter acted"); // see (R14)

	property p_learn;
		learning |-> mem_we && (mem_wdata == {dec_key, dec_serial, rx_cnt})
			##1 !ctrl[`HCR_CTRL_LEARN];
	endproperty
	a_learn: assert property (p_learn) else $error("learn store wrong"); // see (R15)

	property p_func;
		(func_out != '0) |-> $onehot(func_out) && $past(acc) && (func_out[$past(btn) - 4'h1]);
	endproperty
	a_func: assert property (p_func) else $error("wrong output"); // see (R17)

	property p_replace;
		(judging && hold_vld && !too_old && !in_open && !consec)
			|=> (hold_cnt == $past(rx_cnt)) && (func_out == '0);
	endproperty
	a_replace: assert property (p_replace) else $error("held not replaced"); // see (R18)

	c_accept: cover property (acc && in_open);
	c_resync: cover property (acc && !in_open);
	c_learn:  cover property (learning);
	c_reject: cover property (judging && too_old);

endmodule : hcr_sync_check

// *** logic/hcr_params.svh ***
/*
 * offsets, field positions, reset values and timing counts of the
 * rolling-code receiver check block.
 * assumes: included by bare name, clock pclk at 10 MHz.
 */
`ifndef HCR_PARAMS_SVH
`define HCR_PARAMS_SVH

// timing
`define HCR_CLK_MHZ        10
`define HCR_UNIT_MIN_US    200
`define HCR_UNIT_MAX_US    400
`define HCR_UNIT_MIN_CYC   (`HCR_UNIT_MIN_US * `HCR_CLK_MHZ)
`define HCR_UNIT_MAX_CYC   (`HCR_UNIT_MAX_US * `HCR_CLK_MHZ)

// code word layout, first received bit at index 0
`define HCR_WORD_BITS      66
`define HCR_HOP_LSB        0
`define HCR_SER_LSB        32
`define HCR_BTN_LSB        60
`define HCR_LOWBAT_BIT     64
`define HCR_STAT_BIT       65
`define HCR_CNT_W          16

// counter windows
`define HCR_WIN_OPEN       16'h0010

// register offsets
`define HCR_OFS_CTRL       12'h000
`define HCR_OFS_STATUS     12'h004
`define HCR_OFS_MASK       12'h008
`define HCR_OFS_HOP        12'h00c
`define HCR_OFS_SERIAL     12'h010
`define HCR_OFS_INFO       12'h014
`define HCR_OFS_COUNT      12'h018
`define HCR_OFS_FUNC       12'h01c

// control bits
`define HCR_CTRL_EN        0
`define HCR_CTRL_LEARN     1
`define HCR_CTRL_EXT       2
`define HCR_CTRL_RST       3'h0

// status and mask bits
`define HCR_ST_WORD        0
`define HCR_ST_ACC         1
`define HCR_ST_HOLD        2
`define HCR_ST_REJ         3
`define HCR_ST_LRN         4
`define HCR_ST_W           5

`endif

// *** logic/hcr_pkg.sv ***
/*
 * types of the rolling-code receiver check block.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package hcr_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LOOK,
		ST_CMP,
		ST_DEC,
		ST_JUDGE
	} hcr_state_t;

endpackage : hcr_pkg

// *** logic/hcr_store_mem.sv ***
/*
 * transmitter table: one write port, one read port with registered data.
 * assumes: single clock; contents undefined until written.
 */
`timescale 1ns/1ns
module hcr_store_mem #(
	parameter int W     = 112,
	parameter int DEPTH = 4,
	parameter int AW    = 2
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst_n,
	// write side
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	// read side
	input  wire logic [AW-1:0] raddr,
	output logic      [W-1:0]  rdata
);

	logic [W-1:0] mem [DEPTH];

	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata <= '0;
		else
			rdata <= mem[raddr];
	end

endmodule : hcr_store_mem

// *** verif/hcr_tx_model.sv ***
/*
 * transmitter model: keeps a press counter and sends pwm code words.
 * assumes: the caller enters press right after a rising pclk edge.
 */
`timescale 1ns/1ns
module hcr_tx_model #(
	parameter logic [27:0] SERIAL = 28'h5a3c9e1
) (
	// clock
	input  wire logic pclk,
	// radio line
	output logic      rf_data
);
	logic [15:0] cnt;

	initial
	begin
		rf_data = 1'b0;
		cnt     = 16'h0000;
	end

	task automatic hold_line(input logic lvl, input int n);
		rf_data <= lvl;
		repeat (n) @(posedge pclk);
	endtask : hold_line

	// step stands for presses out of range; zero is a replay
	task automatic press(input logic [3:0] btn, input logic [15:0] step, input int unit_cyc,
		input int nb, input logic lb);
		logic [69:0] w;
		cnt = cnt + step;
		if (btn == 4'h0)
			return;
		w = {4'h9, 1'b1, lb, btn, SERIAL, 16'ha5c3, cnt};
		for (int i = 0; i < nb; i++)
		begin
			hold_line(1'b1, w[i] ? unit_cyc : 2 * unit_cyc);
			if (i < nb - 1)
				hold_line(1'b0, w[i] ? 2 * unit_cyc : unit_cyc);
		end
		hold_line(1'b0, 40);
	endtask : press
endmodule : hcr_tx_model

// *** verif/test_hopping_code_receiver_sync_check.sv ***
/*
 * self-checking bench of the rolling-code receiver check block.
 * assumes: identity cipher in the decrypt stand-in, short time-unit parameters.
 */
`timescale 1ns/1ns
`include "hcr_params.svh"
module test_hopping_code_receiver_sync_check;
	localparam logic [27:0] SER = 28'h5a3c9e1;
	localparam logic [63:0] KEY = 64'h0123456789abcdef;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rf_data;
	logic        dec_req;
	logic [31:0] dec_hop;
	logic [63:0] dec_key_in;
	logic        dec_learn;
	logic        dec_done;
	logic [15:0] dec_counter;
	logic [14:0] func_out;
	logic        low_battery;
	logic        irq;
	logic [2:0]  dly;
	logic [63:0] seen_key;
	logic [14:0] last_func;
	int          n_fail;
	int          n_checks;

	hcr_sync_check #(.N_TX(4), .KEY_W(64), .UNIT_MIN_CYC(4), .UNIT_MAX_CYC(8)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rf_data(rf_data), .dec_req(dec_req), .dec_hop(dec_hop),
		.dec_serial(), .dec_key_in(dec_key_in), .dec_learn(dec_learn), .dec_done(dec_done),
		.dec_counter(dec_counter), .dec_key(KEY), .func_out(func_out),
		.low_battery(low_battery), .irq(irq));

	hcr_tx_model #(.SERIAL(SER)) u_tx (.pclk(pclk), .rf_data(rf_data));

	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// decrypt stand-in: counter is the low half of the hopping code
	always @(posedge pclk)
	begin
		dec_done    <= (dly == 3'h1);
		dec_counter <= dec_hop[15:0];
		dly         <= dec_req ? 3'h3 : (dly != 3'h0 ? dly - 3'h1 : 3'h0);
		if (dec_req)
			seen_key <= dec_key_in;
		if (func_out != 15'h0)
			last_func <= func_out;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict;
		if (n_fail == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : give_verdict

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask : rd

	task automatic send(input logic [3:0] b, input logic [15:0] c, input int unit_cyc,
		input int nb, input logic lb);
		wr(`HCR_OFS_STATUS, 32'h1f);
		last_func <= 15'h0;
		u_tx.press(b, c - u_tx.cnt, unit_cyc, nb, lb);
	endtask : send

	task automatic judge(input int bn);
		logic [31:0] st;
		int          k;
		k = 0;
		do
		begin
			rd(`HCR_OFS_STATUS, st);
			k++;
		end
		while ((st & 32'h1e) == 32'h0 && k < 100);
		check("status", st & 32'h1f, 32'h1 | (32'h1 << bn));
	endtask : judge

	task automatic t_reset;
		logic [31:0] q;
		logic        e;
		rd(`HCR_OFS_CTRL, q);
		check("ctrl", q, 32'h0);
		rd(`HCR_OFS_STATUS, q);
		check("status", q, 32'h0);
		check("irq", {31'h0, irq}, 32'h0);
		apb(1'b0, 12'h020, 32'h0, q, e);
		check("unmapped", {q[30:0], e}, 32'h1);
	endtask : t_reset

	task automatic t_learn;
		logic [31:0] q;
		wr(`HCR_OFS_CTRL, 32'h3);
		check("learn line", {31'h0, dec_learn}, 32'h1);
		send(4'h1, 16'h0064, 6, 66, 1'b0);
		judge(`HCR_ST_LRN);
		check("learn line", {31'h0, dec_learn}, 32'h0);
		rd(`HCR_OFS_SERIAL, q);
		check("serial", q, {4'h0, SER});
		rd(`HCR_OFS_HOP, q);
		check("hop", q, 32'ha5c30064);
		rd(`HCR_OFS_INFO, q);
		check("info", q, 32'h21);
		rd(`HCR_OFS_CTRL, q);
		check("ctrl", q, 32'h1);
	endtask : t_learn

	task automatic t_accept;
		logic [31:0] q;
		for (int b = 1; b < 16; b++)
		begin
			send(b[3:0], 16'h0064 + b[15:0], 6, 66, 1'b0);
			judge(`HCR_ST_ACC);
			check("func", {17'h0, last_func}, 32'h1 << (b - 1));
			check("key", seen_key[31:0], KEY[31:0]);
			check("key high", seen_key[63:32], KEY[63:32]);
		end
		send(4'h2, 16'h0083, 6, 66, 1'b1);
		judge(`HCR_ST_ACC);
		rd(`HCR_OFS_COUNT, q);
		check("count", q, 32'h83);
		check("battery", {31'h0, low_battery}, 32'h1);
	endtask : t_accept

	task automatic t_reject;
		logic [15:0] tg[4] = '{16'h0083, 16'h0050, 16'h8083, 16'h9083};
		logic [31:0] q;
		foreach (tg[i])
		begin
			send(4'h1, tg[i], 6, 66, 1'b0);
			judge(`HCR_ST_REJ);
			check("func", {17'h0, last_func}, 32'h0);
		end
		rd(`HCR_OFS_COUNT, q);
		check("count", q, 32'h83);
	endtask : t_reject

	task automatic t_resync;
		logic [31:0] q;
		send(4'h1, 16'h0094, 6, 66, 1'b0);
		judge(`HCR_ST_HOLD);
		send(4'h1, 16'h0200, 6, 66, 1'b0);
		judge(`HCR_ST_HOLD);
		check("func", {17'h0, last_func}, 32'h0);
		send(4'h4, 16'h0201, 6, 66, 1'b0);
		judge(`HCR_ST_ACC);
		check("func", {17'h0, last_func}, 32'h8);
		rd(`HCR_OFS_COUNT, q);
		check("count", q, 32'h201);
	endtask : t_resync

	task automatic t_format;
		logic [31:0] q;
		send(4'h1, 16'h0202, 2, 66, 1'b0);
		send(4'h1, 16'h0203, 14, 66, 1'b0);
		repeat (60) @(posedge pclk);
		rd(`HCR_OFS_STATUS, q);
		check("status", q, 32'h0);
		send(4'h3, 16'h0205, 6, 70, 1'b0);
		judge(`HCR_ST_ACC);
		rd(`HCR_OFS_INFO, q);
		check("info", q, 32'h23);
	endtask : t_format

	task automatic t_ext_irq;
		logic [31:0] q;
		wr(`HCR_OFS_CTRL, 32'h5);
		send(4'h8, 16'h0206, 6, 66, 1'b0);
		judge(`HCR_ST_REJ);
		rd(`HCR_OFS_SERIAL, q);
		check("serial", q, {4'h8, SER});
		wr(`HCR_OFS_MASK, 32'h1);
		check("irq", {31'h0, irq}, 32'h1);
		wr(`HCR_OFS_MASK, 32'h0);
		check("irq", {31'h0, irq}, 32'h0);
		wr(`HCR_OFS_MASK, 32'h1);
		wr(`HCR_OFS_STATUS, 32'h1f);
		check("irq", {31'h0, irq}, 32'h0);
		rd(`HCR_OFS_STATUS, q);
		check("status", q, 32'h0);
		rd(`HCR_OFS_MASK, q);
		check("mask", q, 32'h1);
	endtask : t_ext_irq

	initial
	begin
		repeat (90000) @(posedge pclk);
		n_fail++;
		give_verdict();
	end

	initial
	begin
		n_fail = 0;
		n_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		dec_done = 1'b0;
		dec_counter = 16'h0;
		dly = 3'h0;
		seen_key = 64'h0;
		last_func = 15'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_learn();
		t_accept();
		t_reject();
		t_resync();
		t_format();
		t_ext_irq();
		give_verdict();
	end
endmodule : test_hopping_code_receiver_sync_check
